//--- dpsp_clamp.sv
`timescale 1ns/1ps
// Signed saturating clamp between two bounds.
module dpsp_clamp #(
   parameter int W = 32
) (
   input  wire logic signed [W-1:0] value_i,  // Value to limit.
   input  wire logic signed [W-1:0] lo_i,     // Lower bound.
   input  wire logic signed [W-1:0] hi_i,     // Upper bound.
   output logic signed [W-1:0]      value_o,  // Limited value.
   output logic                     hit_o     // Value was outside bounds.
);

   // Refuse widths that cannot hold a sign and a magnitude.
   if (W < 2) begin : g_bad_width
      $error("dpsp_clamp width too small");
   end

   // If the bounds cross, a value below the lower bound gets it; any other value gets the upper bound.
   always_comb begin
      value_o = value_i;
      hit_o   = 1'b0;
      if (value_i > hi_i) begin
         value_o = hi_i;
         hit_o   = 1'b1;
      end
      if (value_i < lo_i) begin
         value_o = lo_i;
         hit_o   = 1'b1;
      end
   end

endmodule : dpsp_clamp

//--- dpsp_host_model.sv
`timescale 1ns/1ps
// Stand-in for the host and the storage: issues accesses and answers store requests.
module dpsp_host_model (
   input  wire logic              sys_clk_i,   // 25 MHz clock.
   input  wire logic [31:0]       rdata_i,     // Read data from the device.
   input  wire logic              save_req_i,  // Store request level.
   input  wire logic [31:0]       save_dly_i,  // Store latency in cycles.
   output dpsp_pkg::dpsp_access_t acc_o,       // Access to the device.
   output logic                   save_done_o  // Store finished pulse.
);
   logic [31:0] last_rd;        // Word taken with the last answer.
   logic        done_q = 1'b0;  // Store finished pulse register.
   int          cnt = 0;        // Cycles spent on the current store.

   initial acc_o = '0;
   assign save_done_o = done_q;

   // One access: strobe for one cycle, take the answer at the edge after it.
   task automatic access(input logic we, input logic cm, input logic [15:0] a,
                         input logic [31:0] d);
      @(posedge sys_clk_i);
      acc_o <= '{req: 1'b1, we: we, commission: cm, addr: a, wdata: d};
      @(posedge sys_clk_i);
      acc_o.req <= 1'b0;
      @(posedge sys_clk_i);
      last_rd = rdata_i;
   endtask : access

   // Storage is slow, so the host keeps reading until the save reads back 0 or 60 reads are done.
   task automatic poll_save(output int n);
      n = 0;
      do begin
         access(1'b0, 1'b0, dpsp_pkg::ADDR_FACTORY_RESTORE, 32'h0);
         n++;
      end while (last_rd !== 32'h0 && n < 60);
   endtask : poll_save

   // Storage answers a request after a set latency with a one-cycle pulse.
   always @(posedge sys_clk_i) begin
      done_q <= 1'b0;
      cnt    <= save_req_i ? cnt + 1 : 0;
      if (save_req_i && cnt == save_dly_i) begin
         done_q <= 1'b1;
         cnt    <= 0;
      end
   end
endmodule : dpsp_host_model

//--- dpsp_param_core.sv
`timescale 1ns/1ps
// Parameter handling: restore, user reset, direction, scaling and profile targets.
module dpsp_param_core (
   input  wire logic                    sys_clk_i,       // 25 MHz clock.
   input  wire logic                    srst_i,          // Synchronous reset, power-up.
   input  wire dpsp_pkg::dpsp_access_t  acc_i,           // Parameter access.
   output logic [31:0]                  rdata_o,         // Read data.
   output logic                         ack_o,           // Access answered.
   output dpsp_pkg::dpsp_nv_image_t     nv_image_o,      // Image to store.
   output logic                         nv_save_req_o,   // Store request level.
   input  wire logic                    nv_save_done_i,  // Store finished pulse.
   input  wire logic                    standstill_i,    // Axis at standstill.
   input  wire logic [15:0]             ctrl_n_max_i,    // Controller max speed.
   input  wire logic [15:0]             profile_gen_speed_limit_i, // Generator max.
   input  wire logic                    swlim_en_i,      // Software limits enabled.
   input  wire logic signed [31:0]      pos_min_i,       // User position lower limit.
   input  wire logic signed [31:0]      pos_max_i,       // User position upper limit.
   input  wire logic signed [31:0]      act_pos_i,       // Actual motor position.
   output logic                         dir_ccw_o,       // Active direction.
   output logic [31:0]                  active_num_o,    // Active numerator.
   output logic [31:0]                  active_den_o,    // Active denominator.
   output logic [15:0]                  speed_ref_o,     // Limited speed reference.
   output logic signed [31:0]           target_o,        // Move target position.
   output logic                         move_start_o,    // New target pulse.
   output logic                         pos_set_zero_o   // Set actual position to 0.
);

   logic [31:0]        den_q;
   logic [31:0]        num_q;
   logic [15:0]        dir_q;
   logic               dir_act_q;
   logic [15:0]        spd_q;
   logic signed [31:0] abs_q;
   logic signed [31:0] rel_act_q;
   logic signed [31:0] rel_ref_q;
   logic               busy_q;
   logic [31:0]        rdata_q;
   logic               ack_q;
   logic signed [31:0] target_q;
   logic               start_q;
   logic               zero_q;
   logic               wr;
   logic               wr_factory;
   logic               wr_user;
   logic signed [31:0] wval;
   logic signed [31:0] den_lim;
   logic signed [31:0] num_lim;
   logic signed [31:0] lim_lo;
   logic signed [31:0] lim_hi;
   logic signed [31:0] abs_lim;
   logic signed [31:0] rel_sum;
   logic signed [31:0] rel_lim;
   logic               rel_hit;
   logic [15:0]        spd_cap;
   logic signed [15:0] spd_lim;

   assign wr   = acc_i.req && acc_i.we;
   assign wval = acc_i.wdata;

   // Only the commissioning path may restore, and only with the yes code.
   assign wr_factory = wr && (acc_i.addr == dpsp_pkg::ADDR_FACTORY_RESTORE) &&
                       acc_i.commission && (acc_i.wdata[15:0] == dpsp_pkg::FACTORY_CODE_YES); // R4
   assign wr_user    = wr && (acc_i.addr == dpsp_pkg::ADDR_USER_PARAM_RESET) &&
                       acc_i.wdata[dpsp_pkg::USER_RESET_BIT]; // R5

   // Scaling inputs are saturated into their legal range on write.
   dpsp_clamp #(.W(32)) u_den_clamp (
      .value_i (wval),
      .lo_i    (dpsp_pkg::SCALE_MIN),
      .hi_i    (dpsp_pkg::SCALE_MAX),
      .value_o (den_lim),
      .hit_o   ()
   );

   dpsp_clamp #(.W(32)) u_num_clamp (
      .value_i (wval),
      .lo_i    (dpsp_pkg::SCALE_MIN),
      .hi_i    (dpsp_pkg::SCALE_MAX),
      .value_o (num_lim),
      .hit_o   ()
   );

   // Speed ceiling is the smallest of fixed, controller and generator maxima, but not below SPEED_MIN.
   always_comb begin
      spd_cap = dpsp_pkg::SPEED_MAX;
      if (ctrl_n_max_i < spd_cap) begin
         spd_cap = ctrl_n_max_i; // R13
      end
      if (profile_gen_speed_limit_i < spd_cap) begin
         spd_cap = profile_gen_speed_limit_i; // R14
      end
      if (spd_cap < dpsp_pkg::SPEED_MIN) begin
         spd_cap = dpsp_pkg::SPEED_MIN;
      end
   end

   // The stored value keeps the write, held only to 1..13200; the ceiling clamp acts on
   // use, so a later rise of the limits restores the requested speed.
   dpsp_clamp #(.W(16)) u_spd_clamp (
      .value_i ($signed(spd_q)),
      .lo_i    ($signed(dpsp_pkg::SPEED_MIN)),
      .hi_i    ($signed(spd_cap)),
      .value_o (spd_lim),
      .hit_o   ()
   );

   // Position window is the software limits when enabled, else the full range.
   always_comb begin
      lim_lo = $signed(32'h8000_0000);
      lim_hi = $signed(dpsp_pkg::SCALE_MAX);
      if (swlim_en_i) begin
         lim_lo = pos_min_i;
         lim_hi = pos_max_i;
      end
   end

   dpsp_clamp #(.W(32)) u_abs_clamp (
      .value_i (wval),
      .lo_i    (lim_lo),
      .hi_i    (lim_hi),
      .value_o (abs_lim),
      .hit_o   ()
   );

   // Relative targets refer to the actual position or the running target.
   always_comb begin
      rel_sum = act_pos_i + wval; // R16
      if (acc_i.addr == dpsp_pkg::ADDR_TARGET_REL_REF) begin
         rel_sum = target_q + wval; // R17
      end
   end

   dpsp_clamp #(.W(32)) u_rel_clamp (
      .value_i (rel_sum),
      .lo_i    (lim_lo),
      .hi_i    (lim_hi),
      .value_o (rel_lim),
      .hit_o   (rel_hit)
   );

   // Scaling pair: the denominator waits, the numerator applies both.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         den_q        <= dpsp_pkg::RST_SCALE_DENOMINATOR; // R11
         num_q        <= dpsp_pkg::RST_SCALE_NUMERATOR; // R12
         active_den_o <= dpsp_pkg::RST_SCALE_DENOMINATOR;
         active_num_o <= dpsp_pkg::RST_SCALE_NUMERATOR;
      end else if (wr_user) begin
         den_q        <= dpsp_pkg::RST_SCALE_DENOMINATOR; // R5
         num_q        <= dpsp_pkg::RST_SCALE_NUMERATOR;
         active_den_o <= dpsp_pkg::RST_SCALE_DENOMINATOR;
         active_num_o <= dpsp_pkg::RST_SCALE_NUMERATOR;
      end else if (wr && acc_i.addr == dpsp_pkg::ADDR_SCALE_DENOMINATOR) begin
         den_q <= den_lim; // R11
      end else if (wr && acc_i.addr == dpsp_pkg::ADDR_SCALE_NUMERATOR) begin
         num_q        <= num_lim; // R12
         active_num_o <= num_lim; // R10
         active_den_o <= den_q; // R10
      end
   end

   // Direction codes 0 and 1 are stored on write; the active copy is only set, to clockwise, at power-up.
   // A user reset leaves both untouched.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         dir_q     <= dpsp_pkg::RST_ROTATION_DIRECTION;
         dir_act_q <= dpsp_pkg::DIR_CLOCKWISE; // R8
      end else if (wr && acc_i.addr == dpsp_pkg::ADDR_ROTATION_DIRECTION &&
                   acc_i.wdata[15:1] == 15'h0000) begin
         dir_q <= acc_i.wdata[15:0]; // R9
      end
   end

   assign dir_ccw_o = dir_act_q; // R8

   // Speed reference and target registers; speed and absolute target writes saturate, relative offsets are stored as written.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         spd_q     <= dpsp_pkg::RST_PROFILE_SPEED_REF; // R13
         abs_q     <= dpsp_pkg::RST_TARGET; // R15
         rel_act_q <= dpsp_pkg::RST_TARGET;
         rel_ref_q <= dpsp_pkg::RST_TARGET;
      end else if (wr_user) begin
         spd_q     <= dpsp_pkg::RST_PROFILE_SPEED_REF; // R5
         abs_q     <= dpsp_pkg::RST_TARGET;
         rel_act_q <= dpsp_pkg::RST_TARGET;
         rel_ref_q <= dpsp_pkg::RST_TARGET;
      end else if (wr) begin
         if (acc_i.addr == dpsp_pkg::ADDR_PROFILE_SPEED_REF) begin
            spd_q <= (acc_i.wdata[15:0] > dpsp_pkg::SPEED_MAX) ? dpsp_pkg::SPEED_MAX :
                     (acc_i.wdata[15:0] < dpsp_pkg::SPEED_MIN) ? dpsp_pkg::SPEED_MIN :
                     acc_i.wdata[15:0]; // R13
         end
         if (acc_i.addr == dpsp_pkg::ADDR_TARGET_ABS) begin
            abs_q <= abs_lim; // R15
         end
         if (acc_i.addr == dpsp_pkg::ADDR_TARGET_REL_ACTUAL) begin
            rel_act_q <= wval;
         end
         if (acc_i.addr == dpsp_pkg::ADDR_TARGET_REL_REF) begin
            rel_ref_q <= wval;
         end
      end
   end

   assign speed_ref_o = spd_lim; // R14

   // Move start: a target write issues a new target; a relative move from
   // standstill that leaves the window zeroes the position and moves by the
   // offset itself.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         target_q <= dpsp_pkg::RST_TARGET;
         start_q  <= 1'b0;
         zero_q   <= 1'b0;
      end else begin
         start_q <= 1'b0;
         zero_q  <= 1'b0;
         if (wr && acc_i.addr == dpsp_pkg::ADDR_TARGET_ABS) begin
            target_q <= abs_lim; // R15
            start_q  <= 1'b1;
         end else if (wr && (acc_i.addr == dpsp_pkg::ADDR_TARGET_REL_ACTUAL ||
                             acc_i.addr == dpsp_pkg::ADDR_TARGET_REL_REF)) begin
            start_q <= 1'b1;
            if (rel_hit && standstill_i) begin
               zero_q   <= 1'b1; // R19
               target_q <= wval; // R18
            end else begin
               target_q <= rel_lim; // R18
            end
         end
      end
   end

   assign target_o       = target_q;
   assign move_start_o   = start_q;
   assign pos_set_zero_o = zero_q;

   // Save handshake: the done pulse wins only when no new restore arrives.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         busy_q <= 1'b0;
      end else if (wr_factory) begin
         busy_q <= 1'b1; // R1
      end else if (nv_save_done_i) begin
         busy_q <= 1'b0; // R2
      end
   end

   // The stored image holds factory defaults for the next power-up while the
   // running values stay; user resets never reach this image.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         nv_image_o.scale_den <= dpsp_pkg::RST_SCALE_DENOMINATOR;
         nv_image_o.scale_num <= dpsp_pkg::RST_SCALE_NUMERATOR;
         nv_image_o.rot_dir   <= dpsp_pkg::RST_ROTATION_DIRECTION;
         nv_image_o.speed_ref <= dpsp_pkg::RST_PROFILE_SPEED_REF;
      end else if (wr_factory) begin
         nv_image_o.scale_den <= dpsp_pkg::RST_SCALE_DENOMINATOR; // R3
         nv_image_o.scale_num <= dpsp_pkg::RST_SCALE_NUMERATOR;
         nv_image_o.rot_dir   <= dpsp_pkg::RST_ROTATION_DIRECTION;
         nv_image_o.speed_ref <= dpsp_pkg::RST_PROFILE_SPEED_REF;
      end
   end

   assign nv_save_req_o = busy_q; // R7

   // Read mux; unmapped addresses answer zero.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rdata_q <= 32'h0000_0000;
         ack_q   <= 1'b0;
      end else begin
         ack_q <= acc_i.req;
         unique case (acc_i.addr)
            dpsp_pkg::ADDR_FACTORY_RESTORE:    rdata_q <= {31'h0, busy_q}; // R2
            dpsp_pkg::ADDR_USER_PARAM_RESET:   rdata_q <= 32'h0000_0000;
            dpsp_pkg::ADDR_SCALE_DENOMINATOR:  rdata_q <= den_q;
            dpsp_pkg::ADDR_SCALE_NUMERATOR:    rdata_q <= num_q;
            dpsp_pkg::ADDR_ROTATION_DIRECTION: rdata_q <= {16'h0, dir_q};
            dpsp_pkg::ADDR_PROFILE_SPEED_REF:  rdata_q <= {16'h0, spd_q};
            dpsp_pkg::ADDR_TARGET_ABS:         rdata_q <= abs_q;
            dpsp_pkg::ADDR_TARGET_REL_ACTUAL:  rdata_q <= rel_act_q;
            dpsp_pkg::ADDR_TARGET_REL_REF:     rdata_q <= rel_ref_q;
            default:                           rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign rdata_o = rdata_q;
   assign ack_o   = ack_q;

   // Write sequences used by the checks below.
   sequence s_factory_yes;
      wr_factory;
   endsequence

   sequence s_num_write;
      wr && acc_i.addr == dpsp_pkg::ADDR_SCALE_NUMERATOR && !wr_user;
   endsequence

   chk_restore_busy: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      s_factory_yes |=> nv_save_req_o) // R1
      else $error("restore did not start a save");

   chk_busy_reads_one: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (acc_i.req && acc_i.addr == dpsp_pkg::ADDR_FACTORY_RESTORE && !nv_save_done_i &&
       busy_q) |=> rdata_o == 32'h0000_0001) // R2
      else $error("busy save read back zero");

   chk_restore_no_run: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      s_factory_yes |=> $stable(active_num_o) && $stable(dir_ccw_o)) // R3
      else $error("restore changed running values");

   chk_restore_path: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (wr && !acc_i.commission && !busy_q && !nv_save_done_i) |=> !busy_q) // R4
      else $error("restore taken from wrong path");

   chk_user_defaults: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      wr_user |=> den_q == dpsp_pkg::RST_SCALE_DENOMINATOR &&
                  spd_q == dpsp_pkg::RST_PROFILE_SPEED_REF) // R5
      else $error("user reset missed defaults");

   chk_user_keeps_dir: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      wr_user |=> $stable(dir_q)) // R6
      else $error("user reset changed direction");

   chk_user_no_save: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (wr_user && !busy_q) |=> !nv_save_req_o && $stable(nv_image_o)) // R7
      else $error("user reset reached storage");

   chk_dir_deferred: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      ##1 $stable(dir_ccw_o)) // R9
      else $error("direction changed before power-up");

   chk_scale_apply: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      s_num_write |=> active_den_o == den_q && active_num_o == num_q) // R10
      else $error("scaling not applied on numerator");

   chk_den_range: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $signed(den_q) >= 1 && $signed(num_q) >= 1) // R11
      else $error("scaling outside range");

   chk_speed_cap: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      speed_ref_o <= spd_cap && speed_ref_o >= dpsp_pkg::SPEED_MIN) // R14
      else $error("speed reference above ceiling");

   chk_zero_standstill: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      pos_set_zero_o |-> $past(standstill_i) && move_start_o) // R18
      else $error("limits crossed while moving");

   chk_zero_target: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      pos_set_zero_o |-> target_o == $past(wval)) // R19
      else $error("crossing target not offset from zero");

endmodule : dpsp_param_core

//--- dpsp_pkg.sv
// Summary of operation
// R1 - Factory restore writes defaults, then saves them
// R2 - Restore reads non-zero until save completes
// R3 - Restored defaults wait for next power-up
// R4 - Factory restore accepted only from commissioning path
// R5 - User reset bit 0 reloads persistent defaults
// R6 - User reset keeps communication, direction, interface, I/O
// R7 - User reset values are never saved
// R8 - Direction code 0 clockwise, 1 counter-clockwise
// R9 - Direction change stored, active after power-up; the code keeps the active direction clockwise
// R10 - Scaling applied on numerator write only
// R11 - Denominator limited 1 to maximum, default 12
// R12 - Numerator defaults 1, limited 1 to maximum
// R13 - Speed reference 1 to 13200, capped controller maximum
// R14 - Speed reference also clamped to generator maximum
// R15 - Absolute target defaults 0, clamped by limits
// R16 - Relative actual target adds actual motor position
// R17 - Relative reference target adds current target
// R18 - Limits crossed by relative move only at standstill
// R19 - Crossing move first sets actual position zero
package dpsp_pkg;

   // Parameter addresses on the parameter access port.
   localparam logic [15:0] ADDR_USER_PARAM_RESET   = 16'h0410;
   localparam logic [15:0] ADDR_SCALE_DENOMINATOR  = 16'h060e;
   localparam logic [15:0] ADDR_SCALE_NUMERATOR    = 16'h0610;
   localparam logic [15:0] ADDR_ROTATION_DIRECTION = 16'h0618;
   localparam logic [15:0] ADDR_FACTORY_RESTORE    = 16'h0700;
   localparam logic [15:0] ADDR_PROFILE_SPEED_REF  = 16'h0702;
   localparam logic [15:0] ADDR_TARGET_ABS         = 16'h0704;
   localparam logic [15:0] ADDR_TARGET_REL_ACTUAL  = 16'h0706;
   localparam logic [15:0] ADDR_TARGET_REL_REF     = 16'h0708;

   // Values after reset and limits.
   localparam logic [31:0] RST_SCALE_DENOMINATOR  = 32'h0000_000c;
   localparam logic [31:0] RST_SCALE_NUMERATOR    = 32'h0000_0001;
   localparam logic [15:0] RST_ROTATION_DIRECTION = 16'h0000;
   localparam logic [15:0] RST_PROFILE_SPEED_REF  = 16'h003c;
   localparam logic [31:0] RST_TARGET             = 32'h0000_0000;
   localparam logic [31:0] SCALE_MIN              = 32'h0000_0001;
   localparam logic [31:0] SCALE_MAX              = 32'h7fff_ffff;
   localparam logic [15:0] SPEED_MIN              = 16'h0001;
   localparam logic [15:0] SPEED_MAX              = 16'h3390;
   localparam logic [15:0] FACTORY_CODE_MAX       = 16'h0003;
   localparam logic [15:0] FACTORY_CODE_YES       = 16'h0001;
   localparam int          USER_RESET_BIT         = 0;
   localparam logic        DIR_CLOCKWISE          = 1'b0;

   // One parameter access from the fieldbus or commissioning software.
   typedef struct packed {
      logic        req;          // Access strobe.
      logic        we;           // Write when high.
      logic        commission;   // Access arrives via commissioning software.
      logic [15:0] addr;         // Parameter address.
      logic [31:0] wdata;        // Write data.
   } dpsp_access_t;

   // Image handed to non-volatile storage.
   typedef struct packed {
      logic [31:0] scale_den;
      logic [31:0] scale_num;
      logic [15:0] rot_dir;
      logic [15:0] speed_ref;
   } dpsp_nv_image_t;

endpackage : dpsp_pkg

//--- tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the parameter core.
module tb_top;
   logic                     sys_clk_i = 1'b0;
   logic                     srst_i = 1'b1;
   dpsp_pkg::dpsp_access_t   acc;
   dpsp_pkg::dpsp_nv_image_t nv_img;
   logic [31:0]              rdata, a_num, a_den;
   logic                     ack, save_req, save_done, dir_ccw, move_start, pos_zero;
   logic                     standstill = 1'b1, swlim_en = 1'b0;
   logic [15:0]              n_ctrl = 16'hffff, n_gen = 16'hffff, spd;
   logic signed [31:0]       pmin = -32'sd1000, pmax = 32'sd1000, act_pos = '0, tgt;
   int                       save_dly = 3, bad_count = 0, n_compared = 0;
   localparam logic [15:0]   RA [5] = '{16'h060e, 16'h0610, 16'h0702, 16'h0704, 16'h0618};
   localparam logic [31:0]   RV [5] = '{32'h0000_000c, 32'h1, 32'h3c, 32'h0, 32'h0};

   always #20 sys_clk_i = ~sys_clk_i;

   dpsp_param_core uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .acc_i(acc), .rdata_o(rdata),
      .ack_o(ack), .nv_image_o(nv_img), .nv_save_req_o(save_req), .nv_save_done_i(save_done),
      .standstill_i(standstill), .ctrl_n_max_i(n_ctrl), .profile_gen_speed_limit_i(n_gen),
      .swlim_en_i(swlim_en), .pos_min_i(pmin), .pos_max_i(pmax), .act_pos_i(act_pos),
      .dir_ccw_o(dir_ccw), .active_num_o(a_num), .active_den_o(a_den), .speed_ref_o(spd),
      .target_o(tgt), .move_start_o(move_start), .pos_set_zero_o(pos_zero));
   dpsp_host_model host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .save_req_i(save_req),
      .save_dly_i(save_dly), .acc_o(acc), .save_done_o(save_done));

   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Saturating signed limit, the same way the device treats out-of-range writes.
   function automatic logic [31:0] sclamp(input logic signed [31:0] v, lo, hi);
      return (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction : sclamp

   // Stored speed is held to 1..13200, then to the lower of both ceilings.
   function automatic logic [15:0] exp_spd(input logic [15:0] s, c, g);
      logic [15:0] hi;
      hi = 16'h3390;
      if (c < hi) hi = c;
      if (g < hi) hi = g;
      s = (s > 16'h3390) ? 16'h3390 : (s < 16'h0001) ? 16'h0001 : s;
      return (s > hi) ? hi : s;
   endfunction : exp_spd

   task automatic rd(input logic [15:0] a, output logic [31:0] r);
      host.access(1'b0, 1'b0, a, 32'h0);
      r = host.last_rd;
      check("ack", ack, 1'b1);
   endtask : rd

   // A target write must start a move at the answer and may ask for a zero set.
   task automatic tgt_case(input logic [15:0] a, input logic [31:0] v, input logic ss,
                           input logic [31:0] act, input logic [31:0] et, input logic ez);
      standstill <= ss;
      act_pos    <= act;
      host.access(1'b1, 1'b0, a, v);
      check("target", tgt, et);
      check("move start", move_start, 1'b1);
      check("zero set", pos_zero, ez);
   endtask : tgt_case

   // Watchdog sized well above the few hundred cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      bad_count++;
      give_verdict();
   end

   initial begin
      logic [31:0] r, d, n, pt, v, o, pd;
      logic [15:0] s;
      int          k;
      void'($urandom(51677));
      repeat (5) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      // Power-up values, plus an unmapped address that reads as zero.
      for (int i = 0; i < 5; i++) begin
         rd(RA[i], r);
         check("reset value", r, RV[i]);
      end
      rd(16'h0ffe, r);
      check("unmapped", r, 32'h0);
      check("dir after reset", dir_ccw, 1'b0);
      // Scaling: denominator is only stored, the numerator applies both.
      pd = 32'hc;
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 32'h0 : $urandom;
         n = (i == 1) ? 32'h8000_0000 : $urandom;
         host.access(1'b1, 1'b0, dpsp_pkg::ADDR_SCALE_DENOMINATOR, d);
         check("den not yet active", a_den, pd);
         host.access(1'b1, 1'b0, dpsp_pkg::ADDR_SCALE_NUMERATOR, n);
         check("active den", a_den, sclamp(d, 1, 32'sh7fff_ffff));
         check("active num", a_num, sclamp(n, 1, 32'sh7fff_ffff));
         pd = sclamp(d, 1, 32'sh7fff_ffff);
      end
      // Speed reference against random ceilings, corners 0 and above 13200.
      for (int i = 0; i < 5; i++) begin
         s = (i == 0) ? 16'h0 : (i == 1) ? 16'h4e20 : 16'($urandom_range(14000, 1));
         n_ctrl <= (i < 2) ? 16'hffff : 16'($urandom_range(14000, 1));
         n_gen  <= 16'($urandom_range(14000, 1));
         host.access(1'b1, 1'b0, dpsp_pkg::ADDR_PROFILE_SPEED_REF, {16'h0, s});
         rd(dpsp_pkg::ADDR_PROFILE_SPEED_REF, r);
         check("stored speed", r, {16'h0, exp_spd(s, 16'hffff, 16'hffff)});
         check("speed out", spd, exp_spd(s, n_ctrl, n_gen));
      end
      // Direction is stored at once but the active one stays clockwise; bad codes refused.
      host.access(1'b1, 1'b0, dpsp_pkg::ADDR_ROTATION_DIRECTION, 32'h1);
      host.access(1'b1, 1'b0, dpsp_pkg::ADDR_ROTATION_DIRECTION, 32'h2);
      rd(dpsp_pkg::ADDR_ROTATION_DIRECTION, r);
      check("dir stored", r, 32'h1);
      check("dir active", dir_ccw, 1'b0);
      // Restore from the fieldbus path, or with a wrong code, must be ignored.
      host.access(1'b1, 1'b0, dpsp_pkg::ADDR_FACTORY_RESTORE, 32'h1);
      check("restore via bus", save_req, 1'b0);
      host.access(1'b1, 1'b1, dpsp_pkg::ADDR_FACTORY_RESTORE, 32'h2);
      check("restore code 2", save_req, 1'b0);
      save_dly = $urandom_range(20, 2);
      host.access(1'b1, 1'b1, dpsp_pkg::ADDR_FACTORY_RESTORE, 32'h1);
      check("save started", save_req, 1'b1);
      check("img den", nv_img.scale_den, 32'hc);
      check("img num", nv_img.scale_num, 32'h1);
      check("img dir spd", {nv_img.rot_dir, nv_img.speed_ref}, 32'h3c);
      rd(dpsp_pkg::ADDR_FACTORY_RESTORE, r);
      check("save busy", r != 32'h0, 1'b1);
      check("running den kept", a_den, sclamp(d, 1, 32'sh7fff_ffff));
      host.poll_save(k);
      check("save finished", host.last_rd, 32'h0);
      check("save request low", save_req, 1'b0);
      // User reset: bit 0 clear does nothing, set reloads but keeps direction.
      host.access(1'b1, 1'b0, dpsp_pkg::ADDR_USER_PARAM_RESET, 32'h6);
      check("no reset den", a_den, sclamp(d, 1, 32'sh7fff_ffff));
      host.access(1'b1, 1'b0, dpsp_pkg::ADDR_USER_PARAM_RESET, 32'h1);
      check("reset den", a_den, 32'hc);
      check("reset num", a_num, 32'h1);
      rd(dpsp_pkg::ADDR_PROFILE_SPEED_REF, r);
      check("reset speed", r, 32'h3c);
      rd(dpsp_pkg::ADDR_ROTATION_DIRECTION, r);
      check("dir survives", r, 32'h1);
      check("no store", save_req, 1'b0);
      // Targets at random inside and outside a window, axis moving.
      @(posedge sys_clk_i);
      swlim_en <= 1'b1;
      pt = 32'h0;
      for (int i = 0; i < 6; i++) begin
         v = 32'($urandom_range(3000)) - 32'd1500;
         o = 32'($urandom_range(1000)) - 32'd500;
         tgt_case(RA[3], v, 1'b0, o, sclamp(v, pmin, pmax), 1'b0);
         tgt_case(16'h0706, v, 1'b0, o, sclamp(v + o, pmin, pmax), 1'b0);
         pt = sclamp(v + o, pmin, pmax);
         tgt_case(16'h0708, o, 1'b0, 32'h0, sclamp(pt + o, pmin, pmax), 1'b0);
      end
      // Crossing the window is allowed only from standstill, after a zero set.
      tgt_case(16'h0706, 32'd500, 1'b1, 32'd900, 32'd500, 1'b1);
      tgt_case(16'h0708, 32'd1200, 1'b1, 32'd0, 32'd1200, 1'b1);
      tgt_case(16'h0706, 32'd500, 1'b0, 32'd900, 32'd1000, 1'b0);
      @(posedge sys_clk_i);
      swlim_en <= 1'b0;
      tgt_case(RA[3], 32'h7000_0000, 1'b0, 32'h0, 32'h7000_0000, 1'b0);
      give_verdict();
   end
endmodule : tb_top
